/* File: src/adc_out_map.svh */
// Register offsets, field positions, reset values and latency counts of the output control.
`ifndef ADC_OUT_MAP_SVH
`define ADC_OUT_MAP_SVH

// ----------------------------------------------------------------
// Synchronised pin inputs
// ----------------------------------------------------------------
`define PIN_W 6
`define PIN_PWROFF 0
`define PIN_FMT 1
`define PIN_STAB 2
`define PIN_ODIS 3
`define PIN_MODE 4
`define PIN_SCLK 5

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define A_CTRL 12'h000
`define A_STATUS 12'h008
`define A_ODIS 12'h014
`define A_FDCFG 12'h104
`define A_FINE 12'h108
`define A_COARSE 12'h10C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_W 6
`define FDCFG_B_POS 16
`define FINE_LT_POS 16
`define FUT_RST 10'h3C0
`define FLT_RST 10'h100
`define CUT_RST 3'h6

// ----------------------------------------------------------------
// Widths and latencies in sample clock cycles
// ----------------------------------------------------------------
`define CODE_W 11
`define DATA_LAT 12
`define FAST_LAT_DIRECT 2
`define FAST_LAT_SUB 6

`endif

/* File: src/adc_out_pkg.sv */
// Types shared by the converter output control block.
`default_nettype none
`include "adc_out_map.svh"

package adc_out_pkg;

  // ----------------------------------------------------------------
  // Modes and codings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_MAG4 = 3'b000,
    DET_MAG3_OR = 3'b001,
    DET_MAG2_OR_FLT = 3'b010,
    DET_MAG2_CUT_FLT = 3'b011,
    DET_OR_CUT_FUT_FLT = 3'b100,
    DET_OR_FUT_GAIN = 3'b101
  } det_mode_e;

  typedef enum logic [1:0] {
    FMT_OFFSET = 2'b00,
    FMT_TWOS = 2'b01,
    FMT_GRAY = 2'b10
  } fmt_e;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clip;
    logic [`CODE_W-1:0] code;
  } sample_s;

  typedef struct packed {
    det_mode_e mode;
    logic en;
  } det_cfg_s;

  typedef struct packed {
    logic stab;
    logic dclk_inv;
    fmt_e fmt;
    logic stby;
    logic spd;
  } ctrl_s;

  typedef struct packed {
    logic [`PIN_W-1:0] s1;
    logic [`PIN_W-1:0] s2;
    logic [`PIN_W-1:0] s3;
    logic [`PIN_W-1:0] lvl;
    logic [`PIN_W-1:0] rise;
  } sync_state_s;

  typedef struct packed {
    ctrl_s ctrl;
    logic [1:0] odis;
    det_cfg_s [1:0] fdcfg;
    logic [2:0] cut_thr;
    logic [9:0] fut_thr;
    logic [9:0] flt_thr;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [1:0][`CODE_W-1:0] data_out;
    logic [1:0] data_oe;
    logic [1:0][3:0] det_out;
    logic [1:0] det_oe;
    logic [1:0] dclk;
    logic [1:0] dclk_oe;
    logic [1:0] cut_flag;
    logic [1:0] cut_hold;
    logic pd;
    logic stby_act;
    logic ref_on;
    logic stab_out;
  } top_state_s;

endpackage
`default_nettype wire

/* File: src/pin_sync.sv */
// Three-stage synchroniser with agreement filter and rising-edge pulse for the pin inputs.
`default_nettype none
`include "adc_out_map.svh"

module pin_sync
  import adc_out_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [`PIN_W-1:0] pins,
  output logic [`PIN_W-1:0] level,
  output logic [`PIN_W-1:0] rise
);

  sync_state_s st_r;
  sync_state_s st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The first stage feeds only the second; a change counts once stages two and three agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < `PIN_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
    st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
  assign rise = st_r.rise;

endmodule
`default_nettype wire

/* File: src/sample_delay.sv */
// Shift line that advances on each sample enable and exposes every tap.
`default_nettype none

module sample_delay #(
  parameter int unsigned W = 12,
  parameter int unsigned DEPTH = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [DEPTH-1:0][W-1:0] taps
);

  logic [DEPTH-1:0][W-1:0] taps_r;
  logic [DEPTH-1:0][W-1:0] taps_nxt;

  always_comb begin
    taps_nxt = taps_r;
    if (en) begin
      taps_nxt[0] = d;
      for (int i = 1; i < DEPTH; i++) begin
        taps_nxt[i] = taps_r[i-1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taps_r <= '0;
    end else begin
      taps_r <= taps_nxt;
    end
  end

  assign taps = taps_r;

endmodule
`default_nettype wire

/* File: src/adc_output_ctrl.sv */
// Output drivers, code formatting, fast-detect pins and power control of a dual converter.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`default_nettype none
`include "adc_out_map.svh"

module adc_output_ctrl
  import adc_out_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_clk,
  input wire logic power_down_request,
  input wire logic format_select_pin,
  input wire logic stabilizer_select_pin,
  input wire logic monitor_out_disable_pin,
  input wire logic pin_mode_select,
  input wire sample_s [1:0] core_sample,
  input wire logic [1:0][3:0] core_fast_mag,
  output logic [1:0][`CODE_W-1:0] data_out,
  output logic [1:0] data_oe,
  output logic [1:0][3:0] fast_detect_pins,
  output logic [1:0] fast_detect_oe,
  output logic [1:0] data_clock_out,
  output logic [1:0] data_clock_oe,
  output logic core_power_down,
  output logic standby_active,
  output logic reference_power_on,
  output logic duty_cycle_stabilizer
);

  top_state_s st_r;
  top_state_s st_nxt;
  logic [`PIN_W-1:0] pin_lvl;
  logic [`PIN_W-1:0] pin_rise;
  logic pd_now;
  logic stby_now;
  logic smp_en;
  fmt_e fmt_eff;
  logic [1:0][`DATA_LAT-1:0][`CODE_W:0] dtaps;
  logic [1:0][`FAST_LAT_SUB-1:0][3:0] ftaps;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`CODE_W-1:0] fmt_code(input logic [`CODE_W-1:0] c, input fmt_e f);
    case (f)
      FMT_TWOS: return {~c[`CODE_W-1], c[`CODE_W-2:0]};
      FMT_GRAY: return c ^ (c >> 1);
      default: return c;
    endcase
  endfunction

  // Mirror the lower half so that equal excursions either side of mid-scale match.
  function automatic logic [9:0] mag10(input logic [`CODE_W-1:0] c);
    return c[`CODE_W-1] ? c[`CODE_W-2:0] : ~c[`CODE_W-2:0];
  endfunction

  function automatic logic [2:0] fm3(input logic [3:0] m);
    return m[3] ? 3'h7 : m[2:0];
  endfunction

  function automatic logic [1:0] fm2(input logic [3:0] m);
    return (m >= 4'h6) ? 2'h3 : m[2:1];
  endfunction

  // ----------------------------------------------------------------
  // Pins and sample pipelines
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins({sample_clk, pin_mode_select, monitor_out_disable_pin, stabilizer_select_pin,
           format_select_pin, power_down_request}),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  assign pd_now = pin_lvl[`PIN_PWROFF] | st_r.ctrl.spd;
  assign stby_now = st_r.ctrl.stby & ~pd_now;
  // A frozen pipeline in power-down or standby keeps the last samples until wake-up.
  assign smp_en = pin_rise[`PIN_SCLK] & ~pd_now & ~stby_now;
  assign fmt_eff = pin_lvl[`PIN_MODE] ? (pin_lvl[`PIN_FMT] ? FMT_TWOS : FMT_OFFSET)
                                     : st_r.ctrl.fmt;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    sample_delay #(
      .W(`CODE_W + 1),
      .DEPTH(`DATA_LAT)
    ) u_data (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(smp_en),
      .d(core_sample[ch]),
      .taps(dtaps[ch])
    );
    sample_delay #(
      .W(4),
      .DEPTH(`FAST_LAT_SUB)
    ) u_fast (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(smp_en),
      .d(core_fast_mag[ch]),
      .taps(ftaps[ch])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    sample_s s;
    logic [9:0] mag;
    logic [3:0] ff;
    logic [3:0] fs;
    logic orf;
    logic fut;
    logic flt;
    logic cut;
    logic cut_now;
    logic [3:0] det;
    s = '0;
    mag = '0;
    ff = '0;
    fs = '0;
    orf = 1'b0;
    fut = 1'b0;
    flt = 1'b0;
    cut = 1'b0;
    cut_now = 1'b0;
    det = '0;
    st_nxt = st_r;
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;
    st_nxt.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = haddr[11:0];
      st_nxt.hrdata = 32'h0;
      if (!hwrite) begin
        case (haddr[11:0])
          `A_CTRL: st_nxt.hrdata = 32'(st_r.ctrl);
          `A_STATUS: st_nxt.hrdata = {21'h0, st_r.stab_out, st_r.stby_act, st_r.pd, 2'h0, pin_lvl};
          `A_ODIS: st_nxt.hrdata = 32'(st_r.odis);
          `A_FDCFG: st_nxt.hrdata = {12'h0, st_r.fdcfg[1], 12'h0, st_r.fdcfg[0]};
          `A_FINE: st_nxt.hrdata = {6'h0, st_r.flt_thr, 6'h0, st_r.fut_thr};
          `A_COARSE: st_nxt.hrdata = 32'(st_r.cut_thr);
          default: st_nxt.hrdata = 32'h0;
        endcase
      end
    end
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        `A_CTRL: st_nxt.ctrl = ctrl_s'(hwdata[`CTRL_W-1:0]);
        `A_ODIS: st_nxt.odis = hwdata[1:0];
        `A_FDCFG: begin
          st_nxt.fdcfg[0] = det_cfg_s'(hwdata[3:0]);
          st_nxt.fdcfg[1] = det_cfg_s'(hwdata[`FDCFG_B_POS +: 4]);
        end
        `A_FINE: begin
          st_nxt.fut_thr = hwdata[9:0];
          st_nxt.flt_thr = hwdata[`FINE_LT_POS +: 10];
        end
        `A_COARSE: st_nxt.cut_thr = hwdata[2:0];
        default: ;
      endcase
    end

    st_nxt.pd = pd_now;
    st_nxt.stby_act = stby_now;
    st_nxt.ref_on = ~pd_now;
    st_nxt.stab_out = pin_lvl[`PIN_MODE] ? pin_lvl[`PIN_STAB] : st_r.ctrl.stab;

    for (int ch = 0; ch < 2; ch++) begin
      s = sample_s'(dtaps[ch][`DATA_LAT-1]);
      ff = ftaps[ch][`FAST_LAT_DIRECT-1];
      fs = ftaps[ch][`FAST_LAT_SUB-1];
      mag = mag10(s.code);
      orf = s.clip;
      fut = mag > st_r.fut_thr;
      flt = mag < st_r.flt_thr;
      cut = ff > {1'b0, st_r.cut_thr};
      cut_now = cut | st_r.cut_hold[ch];
      case (st_r.fdcfg[ch].mode)
        DET_MAG4: det = ff;
        DET_MAG3_OR: det = {fm3(fs), orf};
        DET_MAG2_OR_FLT: det = {fm2(fs), orf, flt};
        DET_MAG2_CUT_FLT: det = {fm2(fs), cut_now, flt};
        DET_OR_CUT_FUT_FLT: det = {orf, cut_now, fut, flt};
        DET_OR_FUT_GAIN: det = {orf, fut, flt, fut};
        default: det = 4'h0;
      endcase
      if (smp_en) begin
        st_nxt.data_out[ch] = fmt_code(s.code, fmt_eff);
        st_nxt.cut_hold[ch] = cut;
        st_nxt.cut_flag[ch] = cut_now;
        st_nxt.det_out[ch] = det;
      end
      if (!st_r.fdcfg[ch].en) begin
        st_nxt.det_out[ch] = 4'h0;
      end
      // The disable pin is slow by nature; it passes the synchroniser like any strap.
      st_nxt.data_oe[ch] = ~pd_now & ~stby_now & ~pin_lvl[`PIN_ODIS] & ~st_r.odis[ch];
      st_nxt.det_oe[ch] = ~pd_now & ~stby_now & ~st_r.odis[ch] & st_r.fdcfg[ch].en;
      st_nxt.dclk[ch] = ~pin_lvl[`PIN_SCLK] ^ st_r.ctrl.dclk_inv;
      st_nxt.dclk_oe[ch] = st_nxt.data_oe[ch];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.hreadyout <= 1'b1;
      st_r.ctrl.stab <= 1'b1;
      st_r.fut_thr <= `FUT_RST;
      st_r.flt_thr <= `FLT_RST;
      st_r.cut_thr <= `CUT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp = st_r.hresp;
  assign data_out = st_r.data_out;
  assign data_oe = st_r.data_oe;
  assign fast_detect_pins = st_r.det_out;
  assign fast_detect_oe = st_r.det_oe;
  assign data_clock_out = st_r.dclk;
  assign data_clock_oe = st_r.dclk_oe;
  assign core_power_down = st_r.pd;
  assign standby_active = st_r.stby_act;
  assign reference_power_on = st_r.ref_on;
  assign duty_cycle_stabilizer = st_r.stab_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic trk_busy;
  logic trk_chk;
  logic [3:0] trk_cnt;
  logic [`CODE_W-1:0] trk_code;
  fmt_e trk_fmt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trk_busy <= 1'b0;
      trk_chk <= 1'b0;
      trk_cnt <= 4'h0;
      trk_code <= '0;
      trk_fmt <= FMT_OFFSET;
    end else begin
      trk_chk <= 1'b0;
      if (smp_en) begin
        if (!trk_busy) begin
          trk_busy <= 1'b1;
          trk_cnt <= 4'h0;
          trk_code <= core_sample[0].code;
        end else if (trk_cnt == 4'(`DATA_LAT - 1)) begin
          trk_busy <= 1'b0;
          trk_chk <= 1'b1;
          trk_fmt <= fmt_eff;
        end else begin
          trk_cnt <= trk_cnt + 4'h1;
        end
      end
    end
  end

  a_pd_sources:
    assert property ((pin_lvl[`PIN_PWROFF] || st_r.ctrl.spd) |=> core_power_down)
    else $error("power-down request not obeyed");
  a_pd_hiz:
    assert property (core_power_down |-> (data_oe == 2'b00 && fast_detect_oe == 2'b00
                                          && data_clock_oe == 2'b00))
    else $error("driver enabled during power-down");
  a_pd_release:
    assert property ((!pin_lvl[`PIN_PWROFF] && !st_r.ctrl.spd) |=> !core_power_down)
    else $error("power-down not released");
  a_standby_ref:
    assert property (standby_active |-> (reference_power_on && data_oe == 2'b00))
    else $error("standby lost reference or left drivers on");
  a_pin_stab_sel:
    assert property (pin_lvl[`PIN_MODE] |=> duty_cycle_stabilizer == $past(pin_lvl[`PIN_STAB]))
    else $error("stabilizer pin not followed in pin mode");
  a_odis_pin:
    assert property (pin_lvl[`PIN_ODIS] |=> data_oe == 2'b00)
    else $error("data drivers on while disable pin high");
  a_reg_odis:
    assert property (st_r.odis[0] |=> (!data_oe[0] && !fast_detect_oe[0]))
    else $error("channel three-state bit ignored");
  a_data_latency:
    assert property (trk_chk |-> data_out[0] == fmt_code(trk_code, trk_fmt))
    else $error("data output latency or coding wrong");
  a_dclk_phase:
    assert property ($changed(data_out[0]) |-> data_clock_out[0] == $past(st_r.ctrl.dclk_inv))
    else $error("data changed on the capture edge");
  a_fd_off:
    assert property (!st_r.fdcfg[0].en |=> (fast_detect_pins[0] == 4'h0 && !fast_detect_oe[0]))
    else $error("fast-detect active while disabled");
  a_or_pin:
    assert property ((smp_en && st_r.fdcfg[0].en && st_r.fdcfg[0].mode == DET_MAG3_OR)
                     |=> fast_detect_pins[0][0] == $past(dtaps[0][`DATA_LAT-1][`CODE_W]))
    else $error("overrange pin not from pipeline output");
  a_cut_hold:
    assert property ((smp_en && st_r.cut_hold[0]) |=> st_r.cut_flag[0])
    else $error("coarse upper flag dropped too early");

endmodule
`default_nettype wire

/* File: sim/capture_model.sv */
// Behavioural receiver that captures each channel's data on its data clock.
`default_nettype none
`include "adc_out_map.svh"

module capture_model
  import adc_out_pkg::*;
(
  input wire logic [1:0][`CODE_W-1:0] data_out,
  input wire logic [1:0] data_oe,
  input wire logic [1:0] data_clock_out,
  output var logic [1:0][`CODE_W-1:0] captured
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Capture registers
  // ----------------------------------------------------------------
  // Polarity is taken as the default; an inverted clock would need the falling edge here.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always @(posedge data_clock_out[i]) begin
      if (data_oe[i] === 1'b1) begin
        captured[i] <= data_out[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_adc_output_and_fast_detect_control.sv */
// Self-checking bench for the converter output and fast-detect control block.
`default_nettype none
`include "adc_out_map.svh"

module tb_adc_output_and_fast_detect_control
  import adc_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sample_clk;
  logic power_down_request, format_select_pin, stabilizer_select_pin;
  logic monitor_out_disable_pin, pin_mode_select, core_power_down, standby_active;
  logic reference_power_on, duty_cycle_stabilizer;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, data_oe, fast_detect_oe, data_clock_out, data_clock_oe;
  logic [2:0] hsize;
  sample_s [1:0] core_sample;
  logic [1:0][3:0] core_fast_mag, fast_detect_pins;
  logic [1:0][`CODE_W-1:0] data_out, captured;
  wire hready;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [2:0] md[7] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd2};
  logic [10:0] cd[7] = '{11'h7FF, 11'h7FF, 11'h7FF, 11'h7FF, 11'h7FF, 11'h7FF, 11'h400};
  logic [3:0] fm[7] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0};
  logic cl[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [3:0] ex[7] = '{4'h8, 4'hF, 4'hE, 4'hE, 4'hE, 4'hD, 4'h1};
  logic [10:0] code;

  assign hready = hreadyout;

  adc_output_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_clk(sample_clk),
    .power_down_request(power_down_request), .format_select_pin(format_select_pin),
    .stabilizer_select_pin(stabilizer_select_pin),
    .monitor_out_disable_pin(monitor_out_disable_pin), .pin_mode_select(pin_mode_select),
    .core_sample(core_sample), .core_fast_mag(core_fast_mag), .data_out(data_out),
    .data_oe(data_oe), .fast_detect_pins(fast_detect_pins), .fast_detect_oe(fast_detect_oe),
    .data_clock_out(data_clock_out), .data_clock_oe(data_clock_oe),
    .core_power_down(core_power_down), .standby_active(standby_active),
    .reference_power_on(reference_power_on), .duty_cycle_stabilizer(duty_cycle_stabilizer));

  capture_model cap (.data_out(data_out), .data_oe(data_oe), .data_clock_out(data_clock_out),
    .captured(captured));

  // ----------------------------------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // The whole run needs about 4000 cycles, so this ceiling only catches a hang.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic samples(input int n);
    repeat (n) begin
      @(posedge hclk);
      sample_clk <= 1'b1;
      repeat (8) @(posedge hclk);
      sample_clk <= 1'b0;
      repeat (7) @(posedge hclk);
    end
  endtask

  task automatic wt();
    repeat (8) @(posedge hclk);
  endtask

  function automatic logic [10:0] fmtc(input logic [10:0] c, input logic [1:0] f);
    return (f == 2'd1) ? (c ^ 11'h400) : (f == 2'd2) ? (c ^ (c >> 1)) : c;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; sample_clk = 1'b0; power_down_request = 1'b0;
    format_select_pin = 1'b0; stabilizer_select_pin = 1'b1; monitor_out_disable_pin = 1'b0;
    pin_mode_select = 1'b1; core_sample = '0; core_fast_mag = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`A_CTRL, 32'h20);
    rd(`A_ODIS, 32'h0);
    rd(`A_FDCFG, 32'h0);
    rd(`A_FINE, 32'h010003C0);
    rd(`A_COARSE, 32'h6);
    wr(12'h0F0, 32'hFFFFFFFF);
    rd(12'h0F0, 32'h0);
    wt();
    chk(duty_cycle_stabilizer, 1);
    stabilizer_select_pin <= 1'b0;
    wt();
    chk(duty_cycle_stabilizer, 0);
    core_sample[0] <= {1'b0, 11'h123};
    core_sample[1] <= {1'b0, 11'h6AB};
    samples(20);
    chk(data_out, {11'h6AB, 11'h123});
    core_sample[0] <= {1'b0, 11'h555};
    samples(12);
    chk(data_out[0], 11'h123);
    samples(1);
    chk(data_out[0], 11'h555);
    chk(captured[0], 11'h555);
    format_select_pin <= 1'b1;
    wt();
    samples(1);
    chk(data_out[0], 11'h155);
    pin_mode_select <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 3; k++) begin
        code = (k == 0) ? 11'h000 : (k == 1) ? 11'h400 : 11'h7FF;
        core_sample[0] <= {1'b0, code};
        wr(`A_CTRL, 32'h20 | (f << 2));
        samples(13);
        chk(data_out[0], fmtc(code, f[1:0]));
      end
    end
    // Channel B gets the mirror code, so its pins must match channel A.
    for (int i = 0; i < 7; i++) begin
      core_sample[0] <= {cl[i], cd[i]};
      core_sample[1] <= {cl[i], 11'h7FF - cd[i]};
      core_fast_mag <= {fm[i], fm[i]};
      wr(`A_FDCFG, {12'h0, md[i], 1'b1, 12'h0, md[i], 1'b1});
      samples(13);
      chk(fast_detect_pins[0], ex[i]);
      chk(fast_detect_pins[1], ex[i]);
    end
    chk(fast_detect_oe, 2'b11);
    monitor_out_disable_pin <= 1'b1;
    wt();
    chk({data_oe, data_clock_oe, fast_detect_oe}, 6'b000011);
    monitor_out_disable_pin <= 1'b0;
    wr(`A_ODIS, 32'h2);
    wt();
    chk({data_oe, fast_detect_oe}, 4'b0101);
    wr(`A_ODIS, 32'h0);
    power_down_request <= 1'b1;
    wt();
    chk({core_power_down, reference_power_on, data_oe, fast_detect_oe, data_clock_oe},
        8'b10000000);
    power_down_request <= 1'b0;
    wt();
    chk({core_power_down, reference_power_on, data_oe, fast_detect_oe, data_clock_oe},
        8'b01111111);
    wr(`A_CTRL, 32'h21);
    wt();
    chk({core_power_down, data_oe}, 3'b100);
    wr(`A_CTRL, 32'h22);
    wt();
    chk({core_power_down, standby_active, reference_power_on, data_oe}, 5'b01100);
    wr(`A_CTRL, 32'h20);
    end_of_test();
  end
endmodule
`default_nettype wire
